//--- rsa_pkg.sv
// constants and register map shared by the seconds/alarm clock block
package rsa_pkg;
    // timebase and counter geometry
    localparam int unsigned TIMEBASE_HZ = 32768;
    localparam int unsigned SUBSEC_HZ = 4096;
    localparam int unsigned PRE_DIV = TIMEBASE_HZ / SUBSEC_HZ;
    localparam int unsigned PRE_W = $clog2(PRE_DIV);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(PRE_DIV - 1);
    localparam int unsigned SUBSEC_W = 12;
    localparam logic [SUBSEC_W-1:0] SUBSEC_LAST = 12'hfff;
    localparam int unsigned SEC_W = 32;
    localparam int unsigned TOD_W = 20;
    localparam int unsigned SSA_W = 32;
    localparam logic [SSA_W-1:0] SSA_ONE = 32'h0000_0001;
    // trim: parts per million accumulator
    localparam int unsigned TRIM_W = 8;
    localparam int unsigned MAG_W = 7;
    localparam logic [MAG_W-1:0] TRIM_MAX = 7'h7f;
    localparam int unsigned ACC_W = 20;
    localparam logic [ACC_W-1:0] PPM_SCALE = 20'hf_4240;
    // register byte offsets, decoded on the low address byte
    localparam int unsigned OFF_W = 8;
    localparam logic [OFF_W-1:0] OFF_SEC = 8'h00;
    localparam logic [OFF_W-1:0] OFF_SUBSEC = 8'h04;
    localparam logic [OFF_W-1:0] OFF_TOD = 8'h08;
    localparam logic [OFF_W-1:0] OFF_CTRL = 8'h0c;
    localparam logic [OFF_W-1:0] OFF_TRIM = 8'h10;
    localparam logic [OFF_W-1:0] OFF_STAT = 8'h14;
    localparam logic [OFF_W-1:0] OFF_MASK = 8'h18;
    localparam logic [OFF_W-1:0] OFF_SSA = 8'h1c;
    // control bit positions
    localparam int unsigned CTRL_W = 8;
    localparam int unsigned CTL_RUN = 0;
    localparam int unsigned CTL_TOD_EN = 1;
    localparam int unsigned CTL_SS_EN = 2;
    localparam int unsigned CTL_TOD_RPT = 3;
    localparam int unsigned CTL_SS_RPT = 4;
    localparam int unsigned CTL_CAL_EN = 5;
    localparam int unsigned CTL_TOD_WAKE = 6;
    localparam int unsigned CTL_SS_WAKE = 7;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    // status / mask bit positions
    localparam int unsigned FLG_W = 2;
    localparam int unsigned FLG_TOD = 0;
    localparam int unsigned FLG_SS = 1;
    // bus constants
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [TRIM_W-1:0] TRIM_RST = 8'h00;
endpackage

//--- rsa_tick_if.sv
// timebase tick signals passed between the sync, trim and core logic
`timescale 1ns/1ps
interface rsa_tick_if;
    import rsa_pkg::*;
    logic raw_tick; // one rising edge of the timebase pin
    logic adj_tick; // tick after ppm trim
    logic [TRIM_W-1:0] trim; // signed ppm trim value
    modport src (output raw_tick);
    modport trimmer (input raw_tick, input trim, output adj_tick);
    modport core (input adj_tick, output trim);
endinterface

//--- rsa_sync.sv
// three-flop synchroniser and edge detector for the timebase pin
`timescale 1ns/1ps
module rsa_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // timebase pin
    input wire logic pin,
    // tick out
    rsa_tick_if.src bus
);
    import rsa_pkg::*;
    logic s1; // first stage, read only by s2
    logic s2;
    logic s3;
    logic level; // accepted pin level

    // shift chain; no reset needed on a free-running pin
    always_ff @(posedge clk) begin
        s1 <= pin;
        s2 <= s1;
        s3 <= s2;
    end

    // a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            level <= 1'b0;
            bus.raw_tick <= 1'b0;
        end else begin
            bus.raw_tick <= (s2 == s3) && s3 && !level;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule

//--- rsa_trim.sv
// ppm trim: inserts or swallows timebase ticks from a fraction accumulator
`timescale 1ns/1ps
module rsa_trim (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // tick and trim bus
    rsa_tick_if.trimmer bus
);
    import rsa_pkg::*;
    logic [MAG_W-1:0] mag; // |trim|, clamped to the trim limit
    logic [ACC_W-1:0] acc; // ppm fraction accumulator
    logic [ACC_W-1:0] sum;
    logic carry; // a whole tick of correction is due
    logic extra; // pending inserted tick
    logic neg;

    // magnitude; -128 folds onto the limit
    always_comb begin
        neg = bus.trim[TRIM_W-1];
        if (!neg) begin
            mag = bus.trim[MAG_W-1:0];
        end else if (bus.trim[MAG_W-1:0] == '0) begin
            mag = TRIM_MAX;
        end else begin
            mag = MAG_W'(~bus.trim[MAG_W-1:0] + 7'h01);
        end
        sum = acc + ACC_W'(mag);
        carry = sum >= PPM_SCALE;
    end

    // one correction per million ticks per ppm step
    always_ff @(posedge clk) begin
        if (rst) begin
            acc <= '0;
            extra <= 1'b0;
            bus.adj_tick <= 1'b0;
        end else begin
            bus.adj_tick <= (bus.raw_tick && !(carry && neg)) || extra;
            extra <= bus.raw_tick && carry && !neg;
            if (bus.raw_tick) begin
                acc <= carry ? ACC_W'(sum - PPM_SCALE) : sum;
            end
        end
    end
endmodule

//--- rsa_top.sv
// seconds counter with time-of-day and subsecond alarms, trim and AHB-Lite registers
// Function
// - binary 32-bit absolute seconds counter
// - no calendar fields; software converts
// - time-of-day alarm, one second to twelve days
// - independent 32-bit alarm in 1/4096 s
// - each alarm may re-arm itself
// - firing alarm raises interrupt, wake, or both
// - calibration pin carries timebase-derived signal
// - trim rate by +/-127 ppm, 1 ppm steps
// - alarm wakes chip from deep sleep
// - alarm also wakes chip from backup
`timescale 1ns/1ps
module rsa_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // 32.768 kHz timebase pin
    input wire logic XTAL_IN,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // interrupt and wake requests
    output logic IRQ,
    output logic WAKE,
    // calibration pin
    output logic CAL_OUT,
    output logic CAL_OE
);
    import rsa_pkg::*;
    // register map, one word per offset, low address byte decoded:
    //   0x00 seconds, read/write, all 32 bits
    //   0x04 subseconds, low 12 bits; a write also restarts the prescaler
    //   0x08 time-of-day match, low 20 bits of the second to alarm on
    //   0x0c control: run, two alarm enables, two repeat bits,
    //        calibration enable and two wake enables
    //   0x10 signed ppm trim, eight bits
    //   0x14 alarm flags, write one to clear
    //   0x18 interrupt mask, same layout as the flags
    //   0x1c subsecond alarm interval; a write also loads the countdown
    //   any other offset reads zero and ignores writes

    // time state
    logic [SEC_W-1:0] sec; // absolute seconds
    logic [SUBSEC_W-1:0] subsec; // 1/4096 s count
    logic [PRE_W-1:0] pre; // timebase to subsecond divider
    // alarm state
    logic [TOD_W-1:0] tod_match; // low seconds bits to match
    logic [SSA_W-1:0] ss_reload; // subsecond alarm interval
    logic [SSA_W-1:0] ss_count; // ticks left to subsecond alarm
    // software controls and flags
    logic [CTRL_W-1:0] ctrl;
    logic [TRIM_W-1:0] trim;
    logic [FLG_W-1:0] flags; // sticky alarm flags
    logic [FLG_W-1:0] mask; // interrupt enables
    logic [FLG_W-1:0] wake_en;
    logic [FLG_W-1:0] events; // alarm firings this cycle
    // bus data-phase state
    logic wr_pend; // write data phase in progress
    logic [OFF_W-1:0] wr_addr; // offset of that write
    logic addr_hit; // accepted address phase
    // tick decode
    logic sub_tick;
    logic sec_tick;
    logic tod_fire;
    logic ss_fire;
    logic [TOD_W-1:0] next_sec_low;

    // timebase path: pin sync then trim
    // the pin-to-tick latency is a few CLK cycles but fixed, so it shifts
    // every count equally and never changes a rate
    rsa_tick_if tick_bus ();

    // the pin is asynchronous to CLK
    rsa_sync u_sync (
        .clk (CLK),
        .rst (RST),
        .pin (XTAL_IN),
        .bus (tick_bus.src)
    );

    // rate correction sits before the divider so all counts see it
    rsa_trim u_trim (
        .clk (CLK),
        .rst (RST),
        .bus (tick_bus.trimmer)
    );

    // the trim stage reads this on every tick, so a new value acts at once;
    // its accumulator keeps the partial fraction across the change
    assign tick_bus.trim = trim;

    // true when a completed write targets the given offset
    function automatic logic wr_to(input logic pend, input logic [OFF_W-1:0] a,
                                   input logic [OFF_W-1:0] off);
        wr_to = pend && (a == off);
    endfunction

    // readback word for an offset; unmapped offsets read zero
    // narrow fields are zero-extended so reserved bits read zero
    function automatic logic [31:0] rd_word(input logic [OFF_W-1:0] a);
        rd_word = WORD_ZERO;
        unique case (a)
            OFF_SEC: rd_word = sec;
            OFF_SUBSEC: rd_word = 32'(subsec);
            OFF_TOD: rd_word = 32'(tod_match);
            OFF_CTRL: rd_word = 32'(ctrl);
            OFF_TRIM: rd_word = 32'(trim);
            OFF_STAT: rd_word = 32'(flags);
            OFF_MASK: rd_word = 32'(mask);
            OFF_SSA: rd_word = ss_reload;
            default: rd_word = WORD_ZERO;
        endcase
    endfunction

    // only NONSEQ/SEQ with the bus ready start a transfer
    assign addr_hit = HSEL && HREADY && HTRANS[1];

    // capture write address phase; data arrives next cycle
    // a write lands one cycle after its address phase, so a read issued
    // right behind a write to the same word still returns the old value
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_hit && HWRITE;
            if (addr_hit) begin
                wr_addr <= HADDR[OFF_W-1:0];
            end
        end
    end

    // read data is fetched at the address phase so HRDATA is a flop
    always_ff @(posedge CLK) begin
        if (RST) begin
            HRDATA <= WORD_ZERO;
        end else if (addr_hit && !HWRITE) begin
            HRDATA <= rd_word(HADDR[OFF_W-1:0]);
        end
    end

    // zero-wait slave, always OKAY
    // no register needs more than one cycle, so the slave never stretches
    always_ff @(posedge CLK) begin
        if (RST) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end
    end

    // tick decode: divide 32768 to 4096, carry on subsecond wrap
    always_comb begin
        // a tick that meets a subsecond write is dropped, so the written
        // value is not carried into the seconds in that same cycle
        sub_tick = ctrl[CTL_RUN] && tick_bus.adj_tick && (pre == PRE_LAST)
            && !wr_to(wr_pend, wr_addr, OFF_SUBSEC);
        sec_tick = sub_tick && (subsec == SUBSEC_LAST);
        next_sec_low = TOD_W'(sec[TOD_W-1:0] + 20'h0_0001);
        // match on the second being entered, so the alarm fires with it
        tod_fire = sec_tick && ctrl[CTL_TOD_EN] && (next_sec_low == tod_match);
        // a zero interval behaves as one tick
        ss_fire = sub_tick && ctrl[CTL_SS_EN] && (ss_count <= SSA_ONE);
        events = '0;
        events[FLG_TOD] = tod_fire;
        events[FLG_SS] = ss_fire;
    end

    // timebase prescaler; restarts when the subsecond count is written
    // counts zero to seven; the subsecond step falls on the last of eight
    always_ff @(posedge CLK) begin
        if (RST) begin
            pre <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_SUBSEC)) begin
            pre <= '0;
        end else if (ctrl[CTL_RUN] && tick_bus.adj_tick) begin
            pre <= PRE_W'(pre + 3'h1);
        end
    end

    // subsecond counter; wraps to zero after 4096 ticks
    always_ff @(posedge CLK) begin
        if (RST) begin
            subsec <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_SUBSEC)) begin
            subsec <= HWDATA[SUBSEC_W-1:0];
        end else if (sub_tick) begin
            subsec <= SUBSEC_W'(subsec + 12'h001);
        end
    end

    // seconds counter; plain binary, no calendar fields
    // wraps to zero after all ones; the epoch belongs to software
    always_ff @(posedge CLK) begin
        if (RST) begin
            sec <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_SEC)) begin
            sec <= HWDATA;
        end else if (sec_tick) begin
            sec <= SEC_W'(sec + 32'h0000_0001);
        end
    end

    // time-of-day match value; 20 bits cover about twelve days
    // limitation: only the low bits are compared, so the same match comes
    // round again after about twelve days; software keeps targets nearer
    always_ff @(posedge CLK) begin
        if (RST) begin
            tod_match <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_TOD)) begin
            tod_match <= HWDATA[TOD_W-1:0];
        end
    end

    // subsecond alarm interval register
    always_ff @(posedge CLK) begin
        if (RST) begin
            ss_reload <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_SSA)) begin
            ss_reload <= HWDATA;
        end
    end

    // subsecond alarm countdown; reloads on any setup write and on firing
    // a count of zero or one fires on the next subsecond tick
    always_ff @(posedge CLK) begin
        if (RST) begin
            ss_count <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_SSA)) begin
            ss_count <= HWDATA;
        end else if (wr_to(wr_pend, wr_addr, OFF_CTRL)) begin
            ss_count <= ss_reload;
        end else if (ss_fire) begin
            ss_count <= ss_reload;
        end else if (sub_tick && ctrl[CTL_SS_EN]) begin
            ss_count <= SSA_W'(ss_count - SSA_ONE);
        end
    end

    // control; a one-shot alarm disarms itself when it fires
    // a software write in the same cycle wins, so it can re-arm at once
    always_ff @(posedge CLK) begin
        if (RST) begin
            ctrl <= CTRL_RST;
        end else if (wr_to(wr_pend, wr_addr, OFF_CTRL)) begin
            ctrl <= HWDATA[CTRL_W-1:0];
        end else begin
            if (tod_fire && !ctrl[CTL_TOD_RPT]) begin
                ctrl[CTL_TOD_EN] <= 1'b0;
            end
            if (ss_fire && !ctrl[CTL_SS_RPT]) begin
                ctrl[CTL_SS_EN] <= 1'b0;
            end
        end
    end

    // signed ppm trim, handed to the trim stage
    always_ff @(posedge CLK) begin
        if (RST) begin
            trim <= TRIM_RST;
        end else if (wr_to(wr_pend, wr_addr, OFF_TRIM)) begin
            trim <= HWDATA[TRIM_W-1:0];
        end
    end

    // interrupt mask
    always_ff @(posedge CLK) begin
        if (RST) begin
            mask <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_MASK)) begin
            mask <= HWDATA[FLG_W-1:0];
        end
    end

    // sticky flags, write one to clear; a firing in the clear cycle wins
    always_ff @(posedge CLK) begin
        if (RST) begin
            flags <= '0;
        end else if (wr_to(wr_pend, wr_addr, OFF_STAT)) begin
            flags <= (flags & ~HWDATA[FLG_W-1:0]) | events;
        end else begin
            flags <= flags | events;
        end
    end

    // interrupt level follows flags and mask
    // registered so the pin comes from a flop, at one cycle of latency
    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(flags & mask);
        end
    end

    // wake enables map onto the flag layout
    always_comb begin
        wake_en = '0;
        wake_en[FLG_TOD] = ctrl[CTL_TOD_WAKE];
        wake_en[FLG_SS] = ctrl[CTL_SS_WAKE];
    end

    // wake request to the power controller; the same level serves
    // deep sleep and backup, since both share their wake sources
    always_ff @(posedge CLK) begin
        if (RST) begin
            WAKE <= 1'b0;
        end else begin
            WAKE <= |(flags & wake_en);
        end
    end

    // calibration pin: 1 Hz square from the trimmed count, so an
    // external counter sees the effect of the trim directly
    always_ff @(posedge CLK) begin
        if (RST) begin
            CAL_OUT <= 1'b0;
            CAL_OE <= 1'b0;
        end else begin
            CAL_OUT <= ctrl[CTL_CAL_EN] && subsec[SUBSEC_W-1];
            CAL_OE <= ctrl[CTL_CAL_EN];
        end
    end

    // transfer size is ignored: every access acts on a whole word
    // upper address bits alias onto the decoded low window
    logic unused_size;
    assign unused_size = ^{HSIZE, HADDR[31:OFF_W]};
endmodule

//--- rsa_top_props.sv
// concurrent checks on the ports of the seconds/alarm clock block
`timescale 1ns/1ps
module rsa_top_props (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // pins
    input wire logic IRQ,
    input wire logic WAKE,
    input wire logic CAL_OUT,
    input wire logic CAL_OE
);
    import rsa_pkg::*;
    logic rd_req; // read address phase accepted at this edge
    logic [7:0] off; // decoded low address byte
    assign rd_req = HSEL && HTRANS[1] && HREADY && !HWRITE;
    assign off = HADDR[7:0];
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_resp_okay: assert property (HRESP == 1'b0) else $error("error response seen");
    a_ready_high: assert property (HREADYOUT == 1'b1) else $error("wait state seen");
    a_reset_quiet: assert property ($fell(RST) |-> !IRQ && !WAKE && !CAL_OE
        && HRDATA == WORD_ZERO) else $error("outputs not idle after reset");
    a_unmapped_zero: assert property (rd_req && off >= 8'h20 |=> HRDATA == WORD_ZERO)
        else $error("unmapped word read nonzero");
    a_tod_width: assert property (rd_req && off == OFF_TOD |=> HRDATA[31:20] == 12'h000)
        else $error("match word too wide");
    a_subsec_width: assert property (rd_req && off == OFF_SUBSEC
        |=> HRDATA[31:12] == 20'h0_0000) else $error("subsecond word too wide");
    a_flag_width: assert property (rd_req && off == OFF_STAT
        |=> HRDATA[31:2] == 30'h0000_0000) else $error("status word too wide");
    a_data_hold: assert property (!rd_req |=> $stable(HRDATA)) else $error("read data moved");
    a_cal_gate: assert property (!CAL_OE |-> !CAL_OUT) else $error("undriven pin toggles");
    c_irq: cover property ($rose(IRQ));
    c_wake: cover property ($rose(WAKE));
    c_cal: cover property ($rose(CAL_OE));
endmodule
bind rsa_top rsa_top_props rsa_top_props_inst (.CLK(CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IRQ(IRQ), .WAKE(WAKE), .CAL_OUT(CAL_OUT),
    .CAL_OE(CAL_OE));

//--- rsa_xtal_model.sv
// timebase source model: a square wave on the timebase pin while enabled
`timescale 1ns/1ps
module rsa_xtal_model #(
    parameter int HALF = 4 // clk cycles per level; the pin needs at least 2
) (
    // clock
    input wire logic clk,
    // enable; the pin stands low while off
    input wire logic run,
    // timebase pin
    output logic xtal
);
    int cnt = 0; // cycles spent in the current level
    initial xtal = 1'b0;
    // fast stand-in for the crystal, so a second does not take a million cycles
    always @(posedge clk) begin
        if (!run) begin
            cnt <= 0;
            xtal <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            xtal <= ~xtal;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

//--- rsa_top_test.sv
// self-checking bench for the seconds/alarm clock block
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module rsa_top_test;
    import rsa_pkg::*;
    localparam int XHALF = 4; // timebase half period in clk cycles
    // bench-driven signals
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = WORD_ZERO;
    logic [1:0] HTRANS = 2'b00;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = WORD_ZERO;
    logic xtal_on = 1'b0; // timebase model enable
    // design outputs and the bus ready net
    wire logic XTAL_IN, HREADY, HREADYOUT, HRESP, IRQ, WAKE, CAL_OUT, CAL_OE;
    wire logic [31:0] HRDATA;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0; // run length guard
    time t1;
    // write table: six words, unmapped 0x20 included, get all ones; reads keep only each width
    logic [7:0] wa [6] = '{OFF_SEC, OFF_SUBSEC, OFF_TOD, OFF_TRIM, OFF_SSA, 8'h20};
    logic [31:0] we [6] = '{32'hffff_ffff, 32'h0000_0fff, 32'h000f_ffff, 32'h0000_00ff,
        32'hffff_ffff, WORD_ZERO};
    assign HREADY = HREADYOUT; // single slave owns the ready net
    rsa_top rsa_top_inst (.CLK(CLK), .RST(RST), .XTAL_IN(XTAL_IN), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010), .HWDATA(HWDATA),
        .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .IRQ(IRQ), .WAKE(WAKE), .CAL_OUT(CAL_OUT), .CAL_OE(CAL_OE));
    rsa_xtal_model #(.HALF(XHALF)) rsa_xtal_model_inst (.clk(CLK), .run(xtal_on),
        .xtal(XTAL_IN));
    initial forever #4 CLK = ~CLK;
    // a hang counts as a failure
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic [31:0] b(input int p);
        return 32'h0000_0001 << p;
    endfunction
    // one single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h00_0000, a};
        HWRITE <= w;
        @(posedge CLK);
        while (HREADY !== 1'b1) @(posedge CLK);
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= wd;
        @(posedge CLK);
        while (HREADY !== 1'b1) @(posedge CLK);
        q = HRDATA;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, WORD_ZERO, q);
        `CHK(q, e)
    endtask
    // level test at a clock edge; the timeout bounds it
    task automatic wait_irq();
        while (IRQ !== 1'b1) @(posedge CLK);
    endtask
    initial begin
        logic [31:0] s;
        logic [31:0] c;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
        xtal_on <= 1'b1;
        @(posedge CLK);
        // every word, unmapped one included, reads zero out of reset
        for (int i = 0; i <= 8; i++) chk_rd(8'(4 * i), WORD_ZERO);
        for (int i = 0; i < 6; i++) begin
            wr(wa[i], 32'hffff_ffff);
            chk_rd(wa[i], we[i]);
        end
        // one-shot alarm across the 32-bit wrap, then a repeating one
        for (int r = 0; r < 2; r++) begin
            s = (r == 0) ? 32'hffff_ffff : 32'h0000_0004;
            c = b(CTL_RUN) | b(CTL_TOD_EN) | b(CTL_TOD_WAKE) | (r == 1 ? b(CTL_TOD_RPT) : 0);
            wr(OFF_CTRL, WORD_ZERO);
            wr(OFF_SEC, s);
            wr(OFF_TOD, {12'h000, s[19:0] + 20'h0_0001});
            wr(OFF_SUBSEC, 32'h0000_0ff0);
            wr(OFF_MASK, b(FLG_TOD));
            wr(OFF_CTRL, c);
            wait_irq();
            chk_rd(OFF_SEC, s + 32'h0000_0001);
            chk_rd(OFF_STAT, b(FLG_TOD));
            `CHK(WAKE, 1'b1)
            chk_rd(OFF_CTRL, r == 1 ? c : c & ~b(CTL_TOD_EN));
            wr(OFF_STAT, b(FLG_TOD));
            chk_rd(OFF_STAT, WORD_ZERO);
            `CHK(IRQ, 1'b0)
            `CHK(WAKE, 1'b0)
        end
        // repeating subsecond alarm, period of three subsecond ticks
        wr(OFF_CTRL, WORD_ZERO);
        wr(OFF_SSA, 32'h0000_0003);
        wr(OFF_MASK, b(FLG_SS));
        c = b(CTL_RUN) | b(CTL_SS_EN) | b(CTL_SS_RPT) | b(CTL_SS_WAKE);
        wr(OFF_CTRL, c);
        wait_irq();
        t1 = $time;
        wr(OFF_STAT, b(FLG_SS));
        repeat (2) @(posedge CLK);
        wait_irq();
        `CHK($time - t1, 64'(3 * PRE_DIV * 2 * XHALF * 8))
        chk_rd(OFF_CTRL, c);
        wr(OFF_MASK, WORD_ZERO);
        repeat (2) @(posedge CLK);
        `CHK(IRQ, 1'b0)
        `CHK(WAKE, 1'b1)
        chk_rd(OFF_STAT, b(FLG_SS));
        // one-shot subsecond alarm clears its own enable when it fires
        wr(OFF_STAT, b(FLG_SS));
        wr(OFF_MASK, b(FLG_SS));
        wr(OFF_CTRL, b(CTL_RUN) | b(CTL_SS_EN));
        wait_irq();
        chk_rd(OFF_CTRL, b(CTL_RUN));
        // calibration pin follows the top subsecond bit while enabled
        wr(OFF_CTRL, b(CTL_CAL_EN));
        for (int k = 0; k < 2; k++) begin
            wr(OFF_SUBSEC, k == 0 ? 32'h0000_07ff : 32'h0000_0800);
            repeat (2) @(posedge CLK);
            `CHK(CAL_OE, 1'b1)
            `CHK(CAL_OUT, k == 0 ? 1'b0 : 1'b1)
        end
        // disabling the function releases the pin and gates the square
        wr(OFF_CTRL, WORD_ZERO);
        repeat (2) @(posedge CLK);
        `CHK({CAL_OE, CAL_OUT}, 2'b00)
        close_out();
    end
endmodule
